// >>> rtl/seq_pkg.sv
// shared types and constants for the program sequencer core
package seq_pkg;

	// ==========================================================
	// program counter and stack geometry
	localparam int PC_W = 11;
	localparam int PC_HI_W = 3;
	localparam int PC_LO_W = 8;
	localparam int STACK_DEPTH = 6;
	localparam logic [10:0] RESET_VECTOR = 11'h000;
	localparam logic [10:0] IRQ_VECTOR = 11'h004;

	// ==========================================================
	// timing: one instruction cycle is four clock phases
	localparam int CLK_PERIOD_NS = 10;
	localparam int PHASES_PER_CYCLE = 4;
	localparam int INSTR_CYCLE_NS = PHASES_PER_CYCLE * CLK_PERIOD_NS;

	// ==========================================================
	// status register bit positions
	localparam int ST_C = 0;
	localparam int ST_AC = 1;
	localparam int ST_Z = 2;
	localparam int ST_OV = 3;
	localparam logic [3:0] STATUS_RESET = 4'h0;

	// gray-coded instruction phases
	typedef enum logic [1:0] {
		PH_T1 = 2'b00,
		PH_T2 = 2'b01,
		PH_T3 = 2'b11,
		PH_T4 = 2'b10
	} instruction_phases_t;

	// flow-control class of the instruction being executed
	typedef enum logic [2:0] {
		SEQ_NONE = 3'h0,
		SEQ_JUMP_OP = 3'h1,
		SEQ_CALL = 3'h2,
		SEQ_SUBROUTINE_RETURN = 3'h3,
		SEQ_INTERRUPT_RETURN = 3'h4,
		SEQ_PC_LOW_BYTE_WRITE = 3'h5,
		SEQ_SKIP = 3'h6
	} seq_op_t;

	// arithmetic unit operations
	typedef enum logic [3:0] {
		ALU_ADD = 4'h0,
		ALU_ADD_CARRY = 4'h1,
		ALU_SUB = 4'h2,
		ALU_SUB_CARRY = 4'h3,
		ALU_DECIMAL_ADJUST_OP = 4'h4,
		ALU_AND = 4'h5,
		ALU_OR = 4'h6,
		ALU_XOR = 4'h7,
		ALU_COMPLEMENT = 4'h8,
		ALU_ROT_RIGHT = 4'h9,
		ALU_ROT_RIGHT_CARRY = 4'ha,
		ALU_ROT_LEFT = 4'hb,
		ALU_ROT_LEFT_CARRY = 4'hc,
		ALU_INCREMENT = 4'hd,
		ALU_DECREMENT = 4'he
	} alu_op_t;

	// decoded flow command, presented during T2..T4
	typedef struct packed {
		seq_op_t op;
		logic [10:0] target;
		logic skip_met;
		logic [7:0] low_byte;
	} seq_cmd_t;

	// arithmetic request, presented during T2..T4
	typedef struct packed {
		logic valid;
		alu_op_t op;
		logic [7:0] a;
		logic [7:0] b;
	} alu_req_t;

endpackage : seq_pkg

// >>> rtl/mcu_program_sequencer.sv
// instruction phase, program counter, return stack and arithmetic unit
// Behaviour
// - system clock split into four phases; four phases form one instruction cycle
// - counter advances at start of first phase; new instruction fetched then
// - phases two to four decode and execute the instruction
// - fetch of next overlaps execution of current; plain instructions take one cycle
// - jump or call takes two cycles: obtain target, then branch
// - counter increments by one unless control moves to another address
// - counter is 3-bit high part plus 8-bit low byte; only low byte visible
// - jump, call, interrupt or reset load the target into the counter
// - met skip discards the fetched instruction and runs a dummy cycle
// - low byte readable and writable; write jumps within the 256-word page
// - low byte write that branches inserts one dummy prefetch cycle
// - six-level return stack of counter values, hidden from software
// - call and interrupt acknowledge push the counter onto the stack
// - both return kinds restore the counter from the stack top
// - after reset the stack pointer shows an empty stack
// - full stack: interrupt latched, acknowledge withheld until a return frees a level
// - call on full stack still runs and loses the oldest entry
// - arithmetic unit is eight bits wide
// - status flags updated by each arithmetic or logic operation except the two plain rotates
// - add, subtract, decimal adjust, logic, complement, rotates, increment, decrement
// - after reset fetching starts at location zero
`timescale 1ns/1ps

module mcu_program_sequencer #(
	parameter int STACK_DEPTH = seq_pkg::STACK_DEPTH,
	parameter logic [10:0] IRQ_VECTOR = seq_pkg::IRQ_VECTOR
) (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	// decoded instruction for the cycle in execution
	input wire seq_pkg::seq_cmd_t I_CMD,
	input wire seq_pkg::alu_req_t I_ALU,
	// enabled interrupt request pulse
	input wire logic I_IRQ_REQ,
	// fetch side
	output seq_pkg::instruction_phases_t O_PHASE,
	output logic O_FETCH,
	output logic [10:0] O_PC,
	output logic O_DUMMY,
	// software-visible state
	output logic [7:0] O_PC_LOW_BYTE,
	output logic [7:0] O_ALU_RESULT,
	output logic [3:0] O_STATUS,
	// interrupt acknowledge pulse
	output logic O_IRQ_ACK
);

	// ==========================================================
	// sequencer state
	seq_pkg::instruction_phases_t phase, next_phase;
	logic [10:0] pc, next_pc;
	logic dummy, next_dummy;
	logic fetch, next_fetch;
	logic irq_pend, next_irq_pend;
	logic irq_ack, next_irq_ack;
	logic [2:0] depth, next_depth;
	logic [10:0] stack [STACK_DEPTH];
	logic [10:0] next_stack [STACK_DEPTH];
	logic push, pop, execute, full;

	assign full = (depth == 3'(STACK_DEPTH));
	// execution happens in T4 so T2..T3 are left for decode
	assign execute = (phase == seq_pkg::PH_T4) && !dummy;

	// next-state for phase, counter, stack pointer and interrupt
	always_comb begin
		next_phase = seq_pkg::PH_T1;
		next_pc = pc;
		next_dummy = dummy;
		next_irq_ack = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		case (phase)
			seq_pkg::PH_T1: next_phase = seq_pkg::PH_T2;
			seq_pkg::PH_T2: next_phase = seq_pkg::PH_T3;
			seq_pkg::PH_T3: next_phase = seq_pkg::PH_T4;
			seq_pkg::PH_T4: next_phase = seq_pkg::PH_T1;
			default: next_phase = seq_pkg::PH_T1;
		endcase
		if (phase == seq_pkg::PH_T4) begin
			// plain step: next word fetched while this one executes
			next_pc = pc + 11'h001;
			next_dummy = 1'b0;
			if (execute) begin
				case (I_CMD.op)
					seq_pkg::SEQ_JUMP_OP: begin
						next_pc = I_CMD.target;
						next_dummy = 1'b1;
					end
					seq_pkg::SEQ_CALL: begin
						push = 1'b1;
						next_pc = I_CMD.target;
						next_dummy = 1'b1;
					end
					seq_pkg::SEQ_SUBROUTINE_RETURN, seq_pkg::SEQ_INTERRUPT_RETURN: begin
						pop = 1'b1;
						next_pc = stack[0];
						next_dummy = 1'b1;
					end
					seq_pkg::SEQ_PC_LOW_BYTE_WRITE: begin
						// page bits kept, so the jump never leaves its 256 words
						next_pc = {pc[10:8], I_CMD.low_byte};
						next_dummy = 1'b1;
					end
					seq_pkg::SEQ_SKIP: begin
						next_dummy = I_CMD.skip_met;
					end
					seq_pkg::SEQ_NONE: begin
						// acknowledge only between plain instructions, never on full stack
						if (irq_pend && !full) begin
							push = 1'b1;
							next_pc = IRQ_VECTOR;
							next_dummy = 1'b1;
							next_irq_ack = 1'b1;
						end
					end
					default: next_dummy = 1'b0;
				endcase
			end
		end
		// overflow saturates the pointer; the shift drops the oldest level
		if (push) begin
			next_depth = full ? depth : depth + 3'h1;
		end else if (pop && depth != 3'h0) begin
			next_depth = depth - 3'h1;
		end else begin
			next_depth = depth;
		end
		// a new request in the acknowledge cycle stays pending
		next_irq_pend = (irq_pend && !next_irq_ack) || I_IRQ_REQ;
		next_fetch = (next_phase == seq_pkg::PH_T1);
	end

	// return stack as a shift register: entry 0 is the top
	for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
		always_comb begin
			if (push) begin
				next_stack[i] = (i == 0) ? pc : stack[(i == 0) ? 0 : i - 1];
			end else if (pop) begin
				next_stack[i] = (i == STACK_DEPTH - 1) ? 11'h000 : stack[(i == STACK_DEPTH - 1) ? i : i + 1];
			end else begin
				next_stack[i] = stack[i];
			end
		end
		always_ff @(posedge I_CLK) begin
			if (I_SYS_RST) begin
				stack[i] <= 11'h000;
			end else begin
				stack[i] <= next_stack[i];
			end
		end
	end

	// sequencer registers; the first cycle after reset has nothing to execute
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			phase <= seq_pkg::PH_T1;
			pc <= seq_pkg::RESET_VECTOR;
			dummy <= 1'b1;
			fetch <= 1'b1;
			depth <= 3'h0;
			irq_pend <= 1'b0;
			irq_ack <= 1'b0;
		end else begin
			phase <= next_phase;
			pc <= next_pc;
			dummy <= next_dummy;
			fetch <= next_fetch;
			depth <= next_depth;
			irq_pend <= next_irq_pend;
			irq_ack <= next_irq_ack;
		end
	end

	// ==========================================================
	// eight-bit arithmetic unit
	logic [7:0] status_sum_b, next_result, result;
	logic [3:0] status, next_status;
	logic [8:0] sum9;
	logic [4:0] nib;
	logic [7:0] adj;
	logic ci, is_sub;

	// result and flags; carry is read from our own status register
	always_comb begin
		is_sub = (I_ALU.op == seq_pkg::ALU_SUB) || (I_ALU.op == seq_pkg::ALU_SUB_CARRY);
		status_sum_b = is_sub ? ~I_ALU.b : I_ALU.b;
		case (I_ALU.op)
			seq_pkg::ALU_ADD_CARRY, seq_pkg::ALU_SUB_CARRY: ci = status[seq_pkg::ST_C];
			seq_pkg::ALU_SUB: ci = 1'b1;
			default: ci = 1'b0;
		endcase
		// subtraction as a plus not-b plus one: carry set means no borrow
		sum9 = {1'b0, I_ALU.a} + {1'b0, status_sum_b} + {8'h00, ci};
		nib = {1'b0, I_ALU.a[3:0]} + {1'b0, status_sum_b[3:0]} + {4'h0, ci};
		adj = 8'h00;
		next_status = status;
		next_result = result;
		if (execute && I_ALU.valid) begin
			case (I_ALU.op)
				seq_pkg::ALU_ADD, seq_pkg::ALU_ADD_CARRY, seq_pkg::ALU_SUB,
				seq_pkg::ALU_SUB_CARRY: begin
					next_result = sum9[7:0];
					next_status[seq_pkg::ST_C] = sum9[8];
					next_status[seq_pkg::ST_AC] = nib[4];
					next_status[seq_pkg::ST_OV] = (I_ALU.a[7] == status_sum_b[7])
						&& (sum9[7] != I_ALU.a[7]);
				end
				seq_pkg::ALU_DECIMAL_ADJUST_OP: begin
					if (I_ALU.a[3:0] > 4'h9 || status[seq_pkg::ST_AC]) begin
						adj[3:0] = 4'h6;
					end
					if (I_ALU.a > 8'h99 || status[seq_pkg::ST_C]) begin
						adj[7:4] = 4'h6;
					end
					next_result = I_ALU.a + adj;
					next_status[seq_pkg::ST_C] = status[seq_pkg::ST_C] || (adj[7:4] != 4'h0);
				end
				seq_pkg::ALU_AND: next_result = I_ALU.a & I_ALU.b;
				seq_pkg::ALU_OR: next_result = I_ALU.a | I_ALU.b;
				seq_pkg::ALU_XOR: next_result = I_ALU.a ^ I_ALU.b;
				seq_pkg::ALU_COMPLEMENT: next_result = ~I_ALU.a;
				seq_pkg::ALU_ROT_RIGHT: next_result = {I_ALU.a[0], I_ALU.a[7:1]};
				seq_pkg::ALU_ROT_LEFT: next_result = {I_ALU.a[6:0], I_ALU.a[7]};
				seq_pkg::ALU_ROT_RIGHT_CARRY: begin
					next_result = {status[seq_pkg::ST_C], I_ALU.a[7:1]};
					next_status[seq_pkg::ST_C] = I_ALU.a[0];
				end
				seq_pkg::ALU_ROT_LEFT_CARRY: begin
					next_result = {I_ALU.a[6:0], status[seq_pkg::ST_C]};
					next_status[seq_pkg::ST_C] = I_ALU.a[7];
				end
				seq_pkg::ALU_INCREMENT: next_result = I_ALU.a + 8'h01;
				seq_pkg::ALU_DECREMENT: next_result = I_ALU.a - 8'h01;
				default: next_result = result;
			endcase
			// zero flag follows every result except the four rotates, with or without carry
			if (I_ALU.op != seq_pkg::ALU_ROT_RIGHT && I_ALU.op != seq_pkg::ALU_ROT_LEFT
				&& I_ALU.op != seq_pkg::ALU_ROT_RIGHT_CARRY
				&& I_ALU.op != seq_pkg::ALU_ROT_LEFT_CARRY) begin
				next_status[seq_pkg::ST_Z] = (next_result == 8'h00);
			end
		end
	end

	// arithmetic registers, written only in an executing T4
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			result <= 8'h00;
			status <= seq_pkg::STATUS_RESET;
		end else begin
			result <= next_result;
			status <= next_status;
		end
	end

	// ==========================================================
	// outputs, all straight from flip-flops
	assign O_PHASE = phase;
	assign O_FETCH = fetch;
	assign O_PC = pc;
	assign O_DUMMY = dummy;
	assign O_PC_LOW_BYTE = pc[7:0];
	assign O_ALU_RESULT = result;
	assign O_STATUS = status;
	assign O_IRQ_ACK = irq_ack;

	// ==========================================================
	// assertions
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);

	a_phase_cycle: assert property (phase == seq_pkg::PH_T1 |=> phase == seq_pkg::PH_T2 ##1
		phase == seq_pkg::PH_T3 ##1 phase == seq_pkg::PH_T4 ##1 phase == seq_pkg::PH_T1)
		else $error("phase sequence broken");
	// the cycle straight after reset fetches 000 again without a counter step
	a_fetch_first_phase: assert property (fetch && !$past(I_SYS_RST)
		|-> phase == seq_pkg::PH_T1 && $past(phase) == seq_pkg::PH_T4 && $changed(pc))
		else $error("fetch outside first phase");
	a_pc_steady: assert property (phase != seq_pkg::PH_T4 |=> $stable(pc))
		else $error("pc moved outside cycle boundary");
	a_plain_step: assert property (execute && I_CMD.op == seq_pkg::SEQ_NONE && !irq_pend
		|=> pc == $past(pc) + 11'h001 && !dummy)
		else $error("plain instruction did not step by one");
	a_jump_two_cycles: assert property (execute && I_CMD.op == seq_pkg::SEQ_JUMP_OP
		|=> dummy && pc == $past(I_CMD.target) ##4 !dummy)
		else $error("jump did not take two cycles");
	a_skip_dummy: assert property (execute && I_CMD.op == seq_pkg::SEQ_SKIP && I_CMD.skip_met
		|=> dummy && pc == $past(pc) + 11'h001)
		else $error("met skip did not insert dummy");
	a_low_byte_page: assert property (execute && I_CMD.op == seq_pkg::SEQ_PC_LOW_BYTE_WRITE
		|=> dummy && pc[10:8] == $past(pc[10:8]) && pc[7:0] == $past(I_CMD.low_byte))
		else $error("low byte write left its page");
	a_call_push: assert property (execute && I_CMD.op == seq_pkg::SEQ_CALL
		|=> stack[0] == $past(pc) && depth == ($past(full) ? $past(depth) : $past(depth) + 3'h1))
		else $error("call did not push return address");
	a_return_pop: assert property (execute && I_CMD.op == seq_pkg::SEQ_SUBROUTINE_RETURN
		|=> pc == $past(stack[0]))
		else $error("return did not restore counter");
	a_irq_withheld: assert property (full && irq_pend |=> !irq_ack)
		else $error("acknowledge given on full stack");
	a_reset_start: assert property ($past(I_SYS_RST) |-> pc == seq_pkg::RESET_VECTOR && depth == 3'h0)
		else $error("reset did not start at vector zero");

	c_call_overflow: cover property (execute && I_CMD.op == seq_pkg::SEQ_CALL && full);
	c_irq_after_return: cover property (full && irq_pend ##[1:200] irq_ack);
	c_skip_taken: cover property (execute && I_CMD.op == seq_pkg::SEQ_SKIP && I_CMD.skip_met);
	c_low_byte_jump: cover property (execute && I_CMD.op == seq_pkg::SEQ_PC_LOW_BYTE_WRITE);

endmodule : mcu_program_sequencer

// >>> bench/mcu_program_sequencer_tb.sv
// self-checking bench for the program sequencer core
`timescale 1ns/1ps

module mcu_program_sequencer_tb;
	// ==========================================================
	// ports and reference state
	logic I_CLK = 1'b0;
	logic I_SYS_RST = 1'b1;
	logic I_IRQ_REQ = 1'b0;
	seq_pkg::seq_cmd_t I_CMD = '0;
	seq_pkg::alu_req_t I_ALU = '0;
	seq_pkg::instruction_phases_t O_PHASE;
	logic O_FETCH;
	logic [10:0] O_PC;
	logic O_DUMMY;
	logic [7:0] O_PC_LOW_BYTE;
	logic [7:0] O_ALU_RESULT;
	logic [3:0] O_STATUS;
	logic O_IRQ_ACK;
	int mismatches = 0;
	int samples_checked = 0;
	int cyc = 0;
	int last_take = -1;
	int gap = 4;
	logic [31:0] lfsr = 32'h088c;
	logic [10:0] exp_pc;
	logic [10:0] stk[$];
	logic [3:0] exp_st;
	logic [7:0] exp_res;
	logic irq_pend = 1'b0;
	logic check_on = 1'b0;
	logic [1:0] ph_prev = 2'h0;

	mcu_program_sequencer dut_u (
		.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CMD(I_CMD), .I_ALU(I_ALU),
		.I_IRQ_REQ(I_IRQ_REQ), .O_PHASE(O_PHASE), .O_FETCH(O_FETCH), .O_PC(O_PC),
		.O_DUMMY(O_DUMMY), .O_PC_LOW_BYTE(O_PC_LOW_BYTE), .O_ALU_RESULT(O_ALU_RESULT),
		.O_STATUS(O_STATUS), .O_IRQ_ACK(O_IRQ_ACK)
	);

	// 100 mhz clock and a cycle count for spacing checks
	initial begin
		forever #5 I_CLK = ~I_CLK;
	end
	always @(posedge I_CLK) begin
		cyc <= cyc + 1;
	end

	// ==========================================================
	// reporting and comparison
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	task automatic cmp_pc(string nm, logic [10:0] e, logic [10:0] s);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp_pc

	task automatic cmp_byte(string nm, logic [7:0] e, logic [7:0] s);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp_byte

	task automatic cmp_bit(string nm, logic e, logic s);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %b seen %b", nm, e, s);
		end
	endtask : cmp_bit

	// taps 31,21,1,0 keep the sequence long
	function automatic logic [31:0] lfsr_step();
		lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
		return lfsr;
	endfunction : lfsr_step

	function automatic seq_pkg::seq_cmd_t mk(seq_pkg::seq_op_t op, logic [10:0] t, logic m,
		logic [7:0] lb);
		return {op, t, m, lb};
	endfunction : mk

	// reference arithmetic unit, returns {ov, z, ac, c, result}
	function automatic logic [11:0] alu_ref(logic [3:0] op, logic [7:0] a, logic [7:0] b,
		logic [3:0] st);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] bb;
		logic ci;
		logic cin;
		logic [3:0] f;
		f = st;
		ci = st[seq_pkg::ST_C];
		bb = (op == 4'h2 || op == 4'h3) ? ~b : b;
		cin = (op == 4'h2) | ((op == 4'h1 || op == 4'h3) & ci);
		s = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
		h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
		case (op)
			4'h0, 4'h1, 4'h2, 4'h3: f = {a[7] == bb[7] && s[7] != a[7], s[7:0] == 8'h00, h[4], s[8]};
			4'h4: begin
				s = {1'b0, a};
				if (a[3:0] > 4'h9 || st[seq_pkg::ST_AC]) s = s + 9'h006;
				if (s[7:4] > 4'h9 || ci || s[8]) s = s + 9'h060;
				f[seq_pkg::ST_C] = ci | s[8];
			end
			4'h5: s = {1'b0, a & b};
			4'h6: s = {1'b0, a | b};
			4'h7: s = {1'b0, a ^ b};
			4'h8: s = {1'b0, ~a};
			4'h9: s = {1'b0, a[0], a[7:1]};
			4'ha: begin
				s = {1'b0, ci, a[7:1]};
				f[seq_pkg::ST_C] = a[0];
			end
			4'hb: s = {1'b0, a[6:0], a[7]};
			4'hc: begin
				s = {1'b0, a[6:0], ci};
				f[seq_pkg::ST_C] = a[7];
			end
			4'hd: s = {1'b0, a} + 9'h001;
			default: s = {1'b0, a} - 9'h001;
		endcase
		if (op inside {[4'h4:4'h8], 4'hd, 4'he}) f[seq_pkg::ST_Z] = s[7:0] == 8'h00;
		return {f, s[7:0]};
	endfunction : alu_ref

	// ==========================================================
	// drivers
	task automatic do_reset();
		I_SYS_RST = 1'b1;
		check_on = 1'b0;
		repeat (8) @(negedge I_CLK);
		cmp_pc("rst_pc", seq_pkg::RESET_VECTOR, O_PC);
		cmp_bit("rst_dummy", 1'b1, O_DUMMY);
		cmp_bit("rst_ack", 1'b0, O_IRQ_ACK);
		cmp_byte("rst_res", 8'h00, O_ALU_RESULT);
		cmp_byte("rst_st", {4'h0, seq_pkg::STATUS_RESET}, {4'h0, O_STATUS});
		I_SYS_RST = 1'b0;
		stk.delete();
		exp_pc = seq_pkg::RESET_VECTOR + 11'h001;
		exp_st = seq_pkg::STATUS_RESET;
		exp_res = 8'h00;
		irq_pend = 1'b0;
		last_take = -1;
		@(negedge I_CLK);
		check_on = 1'b1;
	endtask : do_reset

	// starts at a negedge well before the next execute phase
	task automatic pulse_irq();
		I_IRQ_REQ = 1'b1;
		@(negedge I_CLK);
		I_IRQ_REQ = 1'b0;
		irq_pend = 1'b1;
	endtask : pulse_irq

	// present one instruction at an executing T4 and check what follows
	task automatic issue(seq_pkg::seq_cmd_t c, seq_pkg::alu_req_t al);
		int n;
		logic [10:0] p;
		logic [10:0] nx;
		logic br;
		logic ack;
		n = 0;
		while (!(O_PHASE === seq_pkg::PH_T4 && O_DUMMY === 1'b0) && n < 64) begin
			@(negedge I_CLK);
			n++;
		end
		if (n >= 64) begin
			mismatches++;
			test_done();
		end
		p = O_PC;
		cmp_pc("fetch_pc", exp_pc, p);
		if (last_take >= 0) cmp_byte("gap", gap[7:0], 8'(cyc - last_take));
		last_take = cyc;
		ack = c.op == seq_pkg::SEQ_NONE && irq_pend && stk.size() < seq_pkg::STACK_DEPTH;
		br = 1'b1;
		nx = p + 11'h001;
		case (c.op)
			seq_pkg::SEQ_JUMP_OP, seq_pkg::SEQ_CALL: nx = c.target;
			seq_pkg::SEQ_SUBROUTINE_RETURN: nx = stk.pop_back();
			seq_pkg::SEQ_INTERRUPT_RETURN: nx = stk.pop_back();
			seq_pkg::SEQ_PC_LOW_BYTE_WRITE: nx = {p[10:8], c.low_byte};
			seq_pkg::SEQ_SKIP: br = c.skip_met;
			default: begin
				br = ack;
				if (ack) nx = seq_pkg::IRQ_VECTOR;
			end
		endcase
		if (c.op == seq_pkg::SEQ_CALL || ack) begin
			if (stk.size() == seq_pkg::STACK_DEPTH) void'(stk.pop_front());
			stk.push_back(p);
		end
		if (al.valid) {exp_st, exp_res} = alu_ref(al.op, al.a, al.b, exp_st);
		I_CMD = c;
		I_ALU = al;
		@(negedge I_CLK);
		I_CMD = '0;
		I_ALU = '0;
		cmp_pc("pc", nx, O_PC);
		cmp_bit("dummy", br, O_DUMMY);
		cmp_bit("irq_ack", ack, O_IRQ_ACK);
		cmp_byte("result", exp_res, O_ALU_RESULT);
		cmp_byte("status", {4'h0, exp_st}, {4'h0, O_STATUS});
		if (ack) irq_pend = 1'b0;
		exp_pc = br ? nx + 11'h001 : nx;
		gap = br ? 8 : 4;
	endtask : issue

	// phase order, fetch strobe and visible low byte, every cycle
	always @(negedge I_CLK) begin
		if (check_on) begin
			cmp_byte("phase", {6'h00, ph_prev[0], ~ph_prev[1]}, {6'h00, O_PHASE});
			cmp_bit("fetch", O_PHASE == seq_pkg::PH_T1, O_FETCH);
			cmp_byte("pc_low", O_PC[7:0], O_PC_LOW_BYTE);
		end
		ph_prev = O_PHASE;
	end

	// ==========================================================
	// main sequence
	initial begin
		seq_pkg::alu_req_t al;
		logic [31:0] r;
		do_reset();
		// every arithmetic operation twice on random operands
		for (int k = 0; k < 30; k++) begin
			r = lfsr_step();
			al = {1'b1, 4'(k % 15), r[7:0], r[15:8]};
			issue(mk(seq_pkg::SEQ_NONE, 11'h000, 1'b0, 8'h00), al);
		end
		// jump to a page end; the low byte write must stay in page 1
		issue(mk(seq_pkg::SEQ_JUMP_OP, 11'h1fe, 1'b0, 8'h00), '0);
		issue(mk(seq_pkg::SEQ_PC_LOW_BYTE_WRITE, 11'h7ff, 1'b0, 8'h05), '0);
		issue(mk(seq_pkg::SEQ_SKIP, 11'h000, 1'b1, 8'h00), '0);
		issue(mk(seq_pkg::SEQ_SKIP, 11'h000, 1'b0, 8'h00), '0);
		// seven calls overflow, six returns of both kinds unwind
		for (int k = 0; k < 13; k++) begin
			r = lfsr_step();
			issue(mk(seq_pkg::seq_op_t'(k < 7 ? seq_pkg::SEQ_CALL : k[0] ?
				seq_pkg::SEQ_INTERRUPT_RETURN : seq_pkg::SEQ_SUBROUTINE_RETURN),
				r[10:0], 1'b0, 8'h00), '0);
		end
		// full stack holds the interrupt back until a return frees a level
		for (int k = 0; k < 6; k++) begin
			r = lfsr_step();
			issue(mk(seq_pkg::SEQ_CALL, r[10:0], 1'b0, 8'h00), '0);
		end
		pulse_irq();
		issue(mk(seq_pkg::SEQ_NONE, 11'h000, 1'b0, 8'h00), '0);
		issue(mk(seq_pkg::SEQ_SUBROUTINE_RETURN, 11'h000, 1'b0, 8'h00), '0);
		issue(mk(seq_pkg::SEQ_NONE, 11'h000, 1'b0, 8'h00), '0);
		// reset with a full stack must leave room for an interrupt
		do_reset();
		pulse_irq();
		issue(mk(seq_pkg::SEQ_NONE, 11'h000, 1'b0, 8'h00), '0);
		issue(mk(seq_pkg::SEQ_INTERRUPT_RETURN, 11'h000, 1'b0, 8'h00), '0);
		test_done();
	end
endmodule : mcu_program_sequencer_tb
